/* File: inc/pin_irq_pkg.sv */
// Constants and types shared by the input pin and interrupt configuration block
package pin_irq_pkg;

	// Register offsets on the control port
	localparam logic [7:0] OFS_FUNC_AB   = 8'h2B;
	localparam logic [7:0] OFS_FUNC_CD   = 8'h2C;
	localparam logic [7:0] OFS_MONITOR   = 8'h2F;
	localparam logic [7:0] OFS_IRQ_CFG   = 8'h32;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h33;
	localparam logic [7:0] OFS_IRQ_LATCH = 8'h36;

	// Reset values
	localparam logic [7:0] RST_FUNC      = 8'h00;
	localparam logic [7:0] RST_IRQ_CFG   = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK  = 8'hFF;
	localparam logic [7:0] RST_IRQ_LATCH = 8'h00;
	localparam logic [7:0] RST_RDATA     = 8'h00;

	// Writable bits of each register
	localparam logic [7:0] WMASK_FUNC    = 8'h77;
	localparam logic [7:0] WMASK_IRQ_CFG = 8'hE4;
	localparam logic [7:0] WMASK_LATCH   = 8'hC0;

	// Field positions
	localparam int FUNC_HI_LSB    = 4;
	localparam int FUNC_LO_LSB    = 0;
	localparam int CFG_POL_BIT    = 7;
	localparam int CFG_MODE_LSB   = 5;
	localparam int CFG_FILTER_BIT = 2;
	localparam int LATCH_CLK_BIT  = 7;
	localparam int LATCH_LOCK_BIT = 6;
	localparam int MON_LSB        = 4;

	// Pin function codes
	typedef enum logic [2:0] {
		FN_DISABLED = 3'h0,
		FN_GPI      = 3'h1,
		FN_MCLK     = 3'h2,
		FN_DAISY    = 3'h3,
		FN_PDM_A    = 3'h4,
		FN_PDM_B    = 3'h5,
		FN_PDM_C    = 3'h6,
		FN_PDM_D    = 3'h7
	} pin_fn_t;

	// Interrupt output modes
	typedef enum logic [1:0] {
		IRQ_LEVEL    = 2'h0,
		IRQ_RESERVED = 2'h1,
		IRQ_REPEAT   = 2'h2,
		IRQ_ONESHOT  = 2'h3
	} irq_mode_t;

	// Timing of the pulsed interrupt modes
	localparam int CLK_FREQ_KHZ   = 125000;
	localparam int PULSE_TIME_MS  = 2;
	localparam int PERIOD_TIME_MS = 4;
	localparam int PULSE_CYCLES   = PULSE_TIME_MS * CLK_FREQ_KHZ;
	localparam int PERIOD_CYCLES  = PERIOD_TIME_MS * CLK_FREQ_KHZ;
	localparam int CNT_W          = 20;
	localparam logic [CNT_W-1:0] RST_CNT = 20'h0_0000;

endpackage : pin_irq_pkg

/* File: verilog/pin_input_sync.sv */
// One input pin: two-stage synchroniser and general-purpose level monitor
`timescale 1ns/1ns

module pin_input_sync (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// Pin and its function
	input  wire logic       pin_raw,
	input  wire logic [2:0] pin_function,
	// Synchronised level and monitor bit
	output logic            pin_level,
	output logic            monitor_bit
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic mon;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	always_comb begin
		d      = q;
		d.meta = pin_raw;
		d.sync = q.meta;
		// Only a general-purpose input reports its level
		d.mon  = (pin_function == pin_irq_pkg::FN_GPI) ? q.sync : 1'b0; // R5 R15
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pin_level   = q.sync;
	assign monitor_bit = q.mon;

endmodule : pin_input_sync

/* File: verilog/input_pin_mux_monitor_irq_cfg.sv */
// Input pin function select, level monitor and interrupt output configuration
`timescale 1ns/1ns

// Behaviour
// (R1) Pin three function at bits 6-4
// (R2) Codes 2,3: master clock, daisy data
// (R3) Codes 4-7: density data pairs a-d
// (R4) Pin four function at bits 2-0
// (R5) Monitor shows general input levels, bits 7-4
// (R6) Monitor low nibble reads zero
// (R7) Polarity bit chooses active low or high
// (R8) Mode 0 level while pending; 1 reserved
// (R9) Mode 2: 2 ms of every 4 ms
// (R10) Mode 3: one 2 ms pulse per event
// (R11) Filter bit hides masked latched bits
// (R12) Reserved config bits zero; fields reset zero
// (R13) Latched status bits clear on read
// (R14) Mask bit per source, reset masked
// (R15) Unselected pins read zero, drive nothing
module input_pin_mux_monitor_irq_cfg #(
	parameter int PULSE_CYCLES  = pin_irq_pkg::PULSE_CYCLES,
	parameter int PERIOD_CYCLES = pin_irq_pkg::PERIOD_CYCLES
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Input pins
	input  wire logic       input_one_pin,
	input  wire logic       input_two_pin,
	input  wire logic       input_three_pin,
	input  wire logic       input_four_pin,
	// Interrupt sources, one-cycle pulses
	input  wire logic       clk_error_event,
	input  wire logic       lock_event,
	// Routed pin functions
	output logic            master_clock_in,
	output logic            daisy_chain_data_in,
	output logic            density_data_pair_a,
	output logic            density_data_pair_b,
	output logic            density_data_pair_c,
	output logic            density_data_pair_d,
	// Interrupt outputs
	output logic            irq_request_pin,
	output logic            irq_level
);

	localparam int CW = pin_irq_pkg::CNT_W;

	typedef struct packed {
		logic [7:0]    func_ab;
		logic [7:0]    func_cd;
		logic [7:0]    cfg;
		logic [7:0]    mask;
		logic [7:0]    latch;
		logic [7:0]    rdata;
		logic [CW-1:0] cnt;
		logic          pulse_on;
		logic          irq_pin;
		logic          irq_lvl;
		logic          mclk;
		logic          daisy;
		logic [3:0]    pdm;
	} state_t;

	state_t q;
	state_t d;

	logic [3:0] pin_raw;
	logic [3:0] pin_level;
	logic [3:0] mon_bit;
	logic [2:0] pin_fn [4];

	assign pin_raw   = {input_four_pin, input_three_pin, input_two_pin, input_one_pin};
	assign pin_fn[0] = q.func_ab[pin_irq_pkg::FUNC_HI_LSB +: 3];
	assign pin_fn[1] = q.func_ab[pin_irq_pkg::FUNC_LO_LSB +: 3];
	assign pin_fn[2] = q.func_cd[pin_irq_pkg::FUNC_HI_LSB +: 3]; // R1
	assign pin_fn[3] = q.func_cd[pin_irq_pkg::FUNC_LO_LSB +: 3]; // R4

	for (genvar i = 0; i < 4; i++) begin : g_pin
		pin_input_sync u_sync (
			.ref_clk      (ref_clk),
			.arst_n       (arst_n),
			.pin_raw      (pin_raw[i]),
			.pin_function (pin_fn[i]),
			.pin_level    (pin_level[i]),
			.monitor_bit  (mon_bit[i])
		);
	end

	always_comb begin
		logic [7:0]    ev;
		logic [7:0]    shown;
		logic [7:0]    clr;
		logic [7:0]    pending;
		logic [7:0]    monitor;
		logic [1:0]    mode;
		logic          active;
		logic          rd_hit;
		logic          wr_hit;
		logic [CW-1:0] period_last;
		logic [CW-1:0] pulse_last;
		logic [CW-1:0] pulse_len;
		ev          = 8'h00;
		shown       = 8'h00;
		clr         = 8'h00;
		pending     = 8'h00;
		monitor     = 8'h00;
		mode        = 2'h0;
		active      = 1'b0;
		rd_hit      = 1'b0;
		wr_hit      = 1'b0;
		period_last = CW'(PERIOD_CYCLES - 1);
		pulse_last  = CW'(PULSE_CYCLES - 1);
		pulse_len   = CW'(PULSE_CYCLES);
		d           = q;

		ev[pin_irq_pkg::LATCH_CLK_BIT]  = clk_error_event;
		ev[pin_irq_pkg::LATCH_LOCK_BIT] = lock_event;
		mode    = q.cfg[pin_irq_pkg::CFG_MODE_LSB +: 2];
		pending = q.latch & ~q.mask & pin_irq_pkg::WMASK_LATCH; // R14

		// Latched readback, optionally without masked sources
		shown = q.cfg[pin_irq_pkg::CFG_FILTER_BIT] ? (q.latch & ~q.mask) : q.latch; // R11

		// Monitor: pin one at bit 7 down to pin four at bit 4, low nibble zero
		monitor[pin_irq_pkg::MON_LSB +: 4] = {mon_bit[0], mon_bit[1], mon_bit[2], mon_bit[3]}; // R5 R6

		// Register writes; reserved bits are never stored
		if (reg_wr) begin
			case (reg_addr)
				pin_irq_pkg::OFS_FUNC_AB: begin
					d.func_ab = reg_wdata & pin_irq_pkg::WMASK_FUNC;
				end
				pin_irq_pkg::OFS_FUNC_CD: begin
					d.func_cd = reg_wdata & pin_irq_pkg::WMASK_FUNC; // R1 R4
				end
				pin_irq_pkg::OFS_IRQ_CFG: begin
					d.cfg = reg_wdata & pin_irq_pkg::WMASK_IRQ_CFG; // R12
				end
				pin_irq_pkg::OFS_IRQ_MASK: begin
					d.mask = reg_wdata; // R14
				end
				pin_irq_pkg::OFS_IRQ_LATCH: begin
					wr_hit = 1'b1;
				end
				default: begin
					wr_hit = 1'b0;
				end
			endcase
		end

		// Read data stands in the following cycle only
		d.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				pin_irq_pkg::OFS_FUNC_AB: begin
					d.rdata = q.func_ab;
				end
				pin_irq_pkg::OFS_FUNC_CD: begin
					d.rdata = q.func_cd;
				end
				pin_irq_pkg::OFS_MONITOR: begin
					d.rdata = monitor;
				end
				pin_irq_pkg::OFS_IRQ_CFG: begin
					d.rdata = q.cfg; // R12
				end
				pin_irq_pkg::OFS_IRQ_MASK: begin
					d.rdata = q.mask;
				end
				pin_irq_pkg::OFS_IRQ_LATCH: begin
					d.rdata = shown;
					rd_hit  = 1'b1;
				end
				default: begin
					d.rdata = 8'h00;
				end
			endcase
		end

		// Reading clears only what was shown; writing a one clears too; a new event wins
		if (rd_hit) begin
			clr = clr | shown; // R13
		end
		if (wr_hit) begin
			clr = clr | reg_wdata;
		end
		d.latch = ((q.latch & ~clr) | ev) & pin_irq_pkg::WMASK_LATCH; // R13

		// Interrupt output timing
		d.pulse_on = 1'b0;
		d.cnt      = pin_irq_pkg::RST_CNT;
		case (mode)
			pin_irq_pkg::IRQ_LEVEL: begin
				active = |pending; // R8
			end
			pin_irq_pkg::IRQ_REPEAT: begin
				// Free-running 4 ms frame while anything stays pending
				if (|pending) begin
					d.cnt = (q.cnt >= period_last) ? pin_irq_pkg::RST_CNT : q.cnt + 1'b1; // R9
				end
				active = (|pending) && (q.cnt < pulse_len); // R9
			end
			pin_irq_pkg::IRQ_ONESHOT: begin
				// Each unmasked event restarts a 2 ms pulse; events inside one merge
				if (|(ev & ~q.mask)) begin
					d.pulse_on = 1'b1; // R10
					d.cnt      = pin_irq_pkg::RST_CNT;
				end else if (q.pulse_on) begin
					d.pulse_on = (q.cnt < pulse_last);
					d.cnt      = q.cnt + 1'b1;
				end
				active = q.pulse_on; // R10
			end
			default: begin
				active = 1'b0; // R8
			end
		endcase
		d.irq_pin = q.cfg[pin_irq_pkg::CFG_POL_BIT] ? active : ~active; // R7
		d.irq_lvl = |pending;

		// Pin routing; a disabled or general pin drives no function
		d.mclk  = 1'b0;
		d.daisy = 1'b0;
		d.pdm   = 4'h0;
		for (int i = 0; i < 4; i++) begin
			case (pin_fn[i])
				pin_irq_pkg::FN_MCLK: begin
					d.mclk = d.mclk | pin_level[i]; // R2
				end
				pin_irq_pkg::FN_DAISY: begin
					d.daisy = d.daisy | pin_level[i]; // R2
				end
				pin_irq_pkg::FN_PDM_A: begin
					d.pdm[0] = d.pdm[0] | pin_level[i]; // R3
				end
				pin_irq_pkg::FN_PDM_B: begin
					d.pdm[1] = d.pdm[1] | pin_level[i]; // R3
				end
				pin_irq_pkg::FN_PDM_C: begin
					d.pdm[2] = d.pdm[2] | pin_level[i]; // R3
				end
				pin_irq_pkg::FN_PDM_D: begin
					d.pdm[3] = d.pdm[3] | pin_level[i]; // R3
				end
				default: begin
					d.mclk = d.mclk; // R15
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q          <= '0;
			q.func_ab  <= pin_irq_pkg::RST_FUNC;
			q.func_cd  <= pin_irq_pkg::RST_FUNC;
			q.cfg      <= pin_irq_pkg::RST_IRQ_CFG; // R12
			q.mask     <= pin_irq_pkg::RST_IRQ_MASK; // R14
			q.latch    <= pin_irq_pkg::RST_IRQ_LATCH;
			q.rdata    <= pin_irq_pkg::RST_RDATA;
			q.cnt      <= pin_irq_pkg::RST_CNT;
			// Default polarity is active low, so the idle pin sits high
			q.irq_pin  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata           = q.rdata;
	assign master_clock_in     = q.mclk;
	assign daisy_chain_data_in = q.daisy;
	assign density_data_pair_a = q.pdm[0];
	assign density_data_pair_b = q.pdm[1];
	assign density_data_pair_c = q.pdm[2];
	assign density_data_pair_d = q.pdm[3];
	assign irq_request_pin     = q.irq_pin;
	assign irq_level           = q.irq_lvl;

endmodule : input_pin_mux_monitor_irq_cfg

/* File: tb/pin_source.sv */
// External pin drivers: static levels or a toggling pattern
`timescale 1ns/1ns

module pin_source (
	// Clock
	input  wire logic       ref_clk,
	// Pattern control
	input  wire logic       run,
	input  wire logic [3:0] lvl,
	// Pins, pin one at bit 3
	output logic      [3:0] pins
);
	logic [3:0] cnt_q = 4'h0;
	initial pins = 4'h0;
	// Pins three and four toggle at different rates so a swap shows
	always @(posedge ref_clk) begin
		cnt_q <= cnt_q + 4'h1;
		pins <= run ? {2'b00, cnt_q[2], cnt_q[3]} : lvl;
	end
endmodule : pin_source

/* File: tb/pin_irq_monitor.sv */
// Port checker for the pin function and interrupt configuration block
`timescale 1ns/1ns

module pin_irq_checker (
	// Clock, reset and register port
	input wire logic       ref_clk,
	input wire logic       arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pins and routed functions
	input wire logic       input_three_pin,
	input wire logic       input_four_pin,
	input wire logic       master_clock_in,
	input wire logic       daisy_chain_data_in,
	input wire logic       density_data_pair_a,
	input wire logic       density_data_pair_b,
	input wire logic       density_data_pair_c,
	input wire logic       density_data_pair_d,
	// Interrupt
	input wire logic       irq_request_pin,
	input wire logic       irq_level
);
	logic [7:0] fab_q;
	logic [7:0] fcd_q;
	logic [7:0] cfg_q;
	logic [2:0] quiet_q;
	logic       calm;
	logic       ok;
	// Shadows of the configuration; quiet_q lets pipelines settle after a write
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fab_q <= 8'h00;
			fcd_q <= 8'h00;
			cfg_q <= 8'h00;
			quiet_q <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == 8'h2b) fab_q <= reg_wdata & 8'h77;
			if (reg_wr && reg_addr == 8'h2c) fcd_q <= reg_wdata & 8'h77;
			if (reg_wr && reg_addr == 8'h32) cfg_q <= reg_wdata & 8'he4;
			quiet_q <= reg_wr ? 3'h0 : (quiet_q == 3'h7 ? 3'h7 : quiet_q + 3'h1);
		end
	end
	assign calm = quiet_q > 3'h3;
	assign ok = calm && fab_q == 8'h00;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	AST_MON_LOW: assert property ($past(reg_rd) && $past(reg_addr) == 8'h2f
		|-> reg_rdata[3:0] == 4'h0) else $error("monitor low bits set");
	AST_CFG_RSV: assert property ($past(reg_rd) && $past(reg_addr) == 8'h32
		|-> reg_rdata == cfg_q) else $error("config readback wrong");
	AST_MCLK: assert property (ok && fcd_q == 8'h20
		|-> master_clock_in == $past(input_three_pin, 3)) else $error("clock route");
	AST_DAISY: assert property (ok && fcd_q == 8'h03
		|-> daisy_chain_data_in == $past(input_four_pin, 3)) else $error("daisy route");
	AST_PDM: assert property (ok && fcd_q == 8'h47 |-> density_data_pair_a ==
		$past(input_three_pin, 3) && density_data_pair_d == $past(input_four_pin, 3)
		&& !density_data_pair_b && !density_data_pair_c) else $error("density route");
	AST_OFF: assert property (ok && fcd_q[6:5] == 2'h0 && fcd_q[2:1] == 2'h0
		|-> !(master_clock_in || daisy_chain_data_in || density_data_pair_a ||
		density_data_pair_b || density_data_pair_c || density_data_pair_d))
		else $error("unselected pin drives a function");
	AST_LEVEL_POL: assert property (calm && cfg_q[6:5] == 2'h0 && $stable(irq_level)
		&& $past(irq_level) == $past(irq_level, 2)
		|-> irq_request_pin == (irq_level ~^ cfg_q[7])) else $error("level polarity");
	AST_RSV_MODE: assert property (calm && cfg_q[6:5] == 2'h1
		|-> irq_request_pin == !cfg_q[7]) else $error("reserved mode not idle");
endmodule : pin_irq_checker

bind input_pin_mux_monitor_irq_cfg pin_irq_checker u_chk (.*);

/* File: tb/tb_input_pin_mux_monitor_irq_cfg.sv */
// Directed test of the pin function and interrupt configuration block
`timescale 1ns/1ns

module tb_input_pin_mux_monitor_irq_cfg;
	logic       ref_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       err_ev = 1'b0;
	logic       lock_ev = 1'b0;
	logic       run = 1'b0;
	logic [3:0] lvl = 4'h0;
	logic [3:0] pins;
	logic [5:0] route;
	logic       irq_pin;
	logic       irq_lvl;
	logic [7:0] seg [4] = '{8'h20, 8'h03, 8'h47, 8'h00};
	logic [7:0] mcfg [3] = '{8'hc0, 8'he0, 8'ha0};
	logic [7:0] mexp [3] = '{8'h10, 8'h08, 8'h00};
	int         err_count = 0;
	int         samples_checked = 0;
	int         n;
	always #4 ref_clk = ~ref_clk;
	pin_source u_src (.ref_clk(ref_clk), .run(run), .lvl(lvl), .pins(pins));
	input_pin_mux_monitor_irq_cfg #(.PULSE_CYCLES(8), .PERIOD_CYCLES(16)) u_dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.input_one_pin(pins[3]), .input_two_pin(pins[2]), .input_three_pin(pins[1]),
		.input_four_pin(pins[0]), .clk_error_event(err_ev), .lock_event(lock_ev),
		.master_clock_in(route[5]), .daisy_chain_data_in(route[4]),
		.density_data_pair_a(route[3]), .density_data_pair_b(route[2]),
		.density_data_pair_c(route[1]), .density_data_pair_d(route[0]),
		.irq_request_pin(irq_pin), .irq_level(irq_lvl));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : cyc
	// Each access ends one edge after its strobe drops, so strobes never re-assert in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, reg_rdata, exp);
		cyc(1);
	endtask : rd
	task automatic ev(input logic e, input logic l);
		err_ev <= e;
		lock_ev <= l;
		@(posedge ref_clk);
		err_ev <= 1'b0;
		lock_ev <= 1'b0;
		cyc(1);
	endtask : ev
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		cyc(1);
		rd(8'h2f, 8'h00, "monitor");
		rd(8'h32, 8'h00, "irq config");
		rd(8'h33, 8'hff, "mask");
		rd(8'h36, 8'h00, "latch");
		rd(8'h2c, 8'h00, "function");
		wr(8'h32, 8'hff);
		rd(8'h32, 8'he4, "irq config");
		wr(8'h2c, 8'hff);
		rd(8'h2c, 8'h77, "function");
		wr(8'h40, 8'h5a);
		rd(8'h40, 8'h00, "unmapped");
		lvl <= 4'hb;
		wr(8'h2b, 8'h11);
		wr(8'h2c, 8'h11);
		cyc(4);
		rd(8'h2f, 8'hb0, "monitor");
		wr(8'h2c, 8'h12);
		cyc(4);
		rd(8'h2f, 8'ha0, "monitor");
		wr(8'h2b, 8'h00);
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 8; c++) begin
				lvl <= p ? 4'h1 : 4'h2;
				wr(8'h2c, p ? 8'(c) : 8'(c << 4));
				cyc(5);
				chk("routed", {2'b00, route}, c > 1 ? 8'h20 >> (c - 2) : 8'h00);
			end
		end
		run <= 1'b1;
		foreach (seg[i]) begin
			wr(8'h2c, seg[i]);
			cyc(24);
		end
		run <= 1'b0;
		wr(8'h33, 8'h3f);
		wr(8'h32, 8'h80);
		ev(1'b1, 1'b0);
		cyc(3);
		chk("irq level", {7'h0, irq_lvl}, 8'h01);
		chk("irq pin", {7'h0, irq_pin}, 8'h01);
		wr(8'h32, 8'h00);
		cyc(2);
		chk("irq pin", {7'h0, irq_pin}, 8'h00);
		rd(8'h36, 8'h80, "latch");
		rd(8'h36, 8'h00, "latch");
		cyc(3);
		chk("irq pin", {7'h0, irq_pin}, 8'h01);
		wr(8'h33, 8'hff);
		ev(1'b0, 1'b1);
		cyc(3);
		chk("irq level", {7'h0, irq_lvl}, 8'h00);
		wr(8'h32, 8'h04);
		rd(8'h36, 8'h00, "latch");
		wr(8'h32, 8'h00);
		rd(8'h36, 8'h40, "latch");
		wr(8'h33, 8'h3f);
		// Windows of two full periods make the count independent of phase
		// Sampling opens on the edge after the event, where a one-shot pulse starts
		foreach (mcfg[i]) begin
			wr(8'h32, mcfg[i]);
			ev(1'b1, 1'b0);
			n = 0;
			repeat (32) begin
				n += (irq_pin === 1'b1);
				cyc(1);
			end
			chk("active cycles", 8'(n), mexp[i]);
			rd(8'h36, 8'h80, "latch");
			cyc(20);
		end
		wrap_up();
	end
endmodule : tb_input_pin_mux_monitor_irq_cfg
